// ### logic/cte_consts.svh
`ifndef CTE_CONSTS_SVH
`define CTE_CONSTS_SVH
`define CTE_OFF_CTRL      8'h00
`define CTE_OFF_CONFIG    8'h04
`define CTE_OFF_STATUS    8'h08
`define CTE_OFF_WIN       8'h0C
`define CTE_OFF_SCNT      8'h10
`define CTE_OFF_TOTAL     8'h14
`define CTE_OFF_IRQ_STAT  8'h18
`define CTE_OFF_IRQ_MASK  8'h1C
`define CTE_OFF_RD_ADDR   8'h20
`define CTE_OFF_RD_DATA   8'h24
`define CTE_OFF_KEPT      8'h28
`define CTE_CTRL_ARM      0
`define CTE_CTRL_ARM_NOW  1
`define CTE_CTRL_STOP     2
`define CTE_CTRL_DONE     3
`define CTE_CFG_TPOS_LSB  0
`define CTE_CFG_DLOG_LSB  16
`define CTE_CFG_NLOG_LSB  24
`define CTE_CFG_ADV_BIT   31
`define CTE_ST_STATE_LSB  0
`define CTE_ST_TSTATE_LSB 8
`define CTE_ST_FLAGS_LSB  12
`define CTE_IRQ_TRIG      0
`define CTE_IRQ_FULL      1
`define CTE_IRQ_STOP      2
`define CTE_RST_CONFIG    32'h001F0000
`define CTE_RST_MASK      3'h0
`define CTE_RESP_OKAY     2'h0
`define CTE_RESP_SLVERR   2'h2
`endif

// ### logic/cte_pkg.sv
package cte_pkg;
  typedef enum logic [4:0] {
    CTE_IDLE = 5'h01,
    CTE_PRE  = 5'h02,
    CTE_WAIT = 5'h04,
    CTE_POST = 5'h08,
    CTE_FULL = 5'h10
  } cte_state_t;

  typedef struct packed {
    logic        adv;
    logic [2:0]  rsv_hi;
    logic [3:0]  nwin_log2;
    logic [2:0]  rsv_mid;
    logic [4:0]  depth_log2;
    logic [15:0] trig_pos;
  } cte_cfg_t;

  typedef struct packed {
    logic arm;
    logic arm_now;
    logic stop;
    logic done;
  } cte_cmd_t;
endpackage : cte_pkg

// ### logic/cte_mem.sv
`timescale 1ns/1ps
`default_nettype none
module cte_mem #(
  parameter int W  = 9,
  parameter int AW = 10
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);
  logic [W-1:0] mem [2**AW];

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule : cte_mem
`default_nettype wire

// ### logic/cte_engine.sv
// Contract
// - trigger position any index in window
// - run-time power-of-two depth up to maximum
// - normal arm waits for trigger event
// - immediate arm triggers at once
// - stop halts, keeps filled and triggered windows
// - idle arm: wait if position 0, else pre
// - pre-trigger stores samples, then waits
// - trigger at last sample ends window (full if last window), else post
// - post-trigger fills rest, then next window, or full after last window
// - full holds data until host upload done
// - no capture between full and re-arm
// - window, sample, total counters clear in idle
// - advanced mode exposes four state machine flags
// - advanced mode reports trigger state while waiting
// - buffer split into equal windows with marks
// - position 0: ready cycle after previous window
`timescale 1ns/1ps
`default_nettype none
`include "cte_consts.svh"
module cte_engine
  import cte_pkg::*;
#(
  parameter int PROBE_W = 8,
  parameter int AW      = 10
) (
  input  wire logic               MCLK_I,
  input  wire logic               RST_I,
  input  wire logic [PROBE_W-1:0] PROBE_I,
  input  wire logic               TRIG_I,
  input  wire logic [3:0]         TSM_STATE_I,
  input  wire logic [3:0]         TSM_FLAGS_I,
  input  wire logic [7:0]         S_AXI_AWADDR,
  input  wire logic               S_AXI_AWVALID,
  output logic                    S_AXI_AWREADY,
  input  wire logic [31:0]        S_AXI_WDATA,
  input  wire logic [3:0]         S_AXI_WSTRB,
  input  wire logic               S_AXI_WVALID,
  output logic                    S_AXI_WREADY,
  output logic [1:0]              S_AXI_BRESP,
  output logic                    S_AXI_BVALID,
  input  wire logic               S_AXI_BREADY,
  input  wire logic [7:0]         S_AXI_ARADDR,
  input  wire logic               S_AXI_ARVALID,
  output logic                    S_AXI_ARREADY,
  output logic [31:0]             S_AXI_RDATA,
  output logic [1:0]              S_AXI_RRESP,
  output logic                    S_AXI_RVALID,
  input  wire logic               S_AXI_RREADY,
  output logic                    IRQ_O
);
  initial
  begin
    if (AW < 1 || AW > 16 || PROBE_W < 1 || PROBE_W > 31)
    begin
      $error("cte_engine: unsupported AW or PROBE_W");
    end
  end

  function automatic logic [AW-1:0] lg_mask(input logic [4:0] n);
    logic [AW-1:0] m;
    m = '0;
    for (int i = 0; i < AW; i++)
    begin
      m[i] = (5'(i) < n);
    end
    return m;
  endfunction : lg_mask

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (s[b])
      begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // bus slave state
  logic        aw_hold_r;
  logic [7:0]  aw_addr_r;
  logic        w_hold_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_en;
  logic        rd_take;
  cte_cmd_t    cmd;
  cte_cfg_t    cfg_r;
  logic [2:0]  irq_stat_r;
  logic [2:0]  irq_mask_r;
  logic [AW-1:0] rd_addr_r;
  logic [PROBE_W:0] mem_q;
  logic [31:0] rd_mux;
  logic [1:0]  rd_resp;

  // engine state
  cte_state_t      state_r;
  logic [AW-1:0]   scnt_r;
  logic [AW-1:0]   win_r;
  logic [AW:0]     total_r;
  logic [AW:0]     kept_r;
  logic            imm_r;
  logic [4:0]      nlog;
  logic [4:0]      dlog;
  logic [AW-1:0]   dmask;
  logic [AW-1:0]   nmask;
  logic [AW-1:0]   tpos;
  logic            trig;
  logic            active;
  logic            mem_we;
  logic [AW-1:0]   mem_waddr;
  logic            ev_trig;
  logic            ev_full;
  logic            ev_stop;

  assign wr_en   = aw_hold_r && w_hold_r && !S_AXI_BVALID;
  assign rd_take = S_AXI_ARVALID && S_AXI_ARREADY;
  assign cmd.arm     = wr_en && aw_addr_r == `CTE_OFF_CTRL && w_strb_r[0]
                       && w_data_r[`CTE_CTRL_ARM];
  assign cmd.arm_now = wr_en && aw_addr_r == `CTE_OFF_CTRL && w_strb_r[0]
                       && w_data_r[`CTE_CTRL_ARM_NOW];
  assign cmd.stop    = wr_en && aw_addr_r == `CTE_OFF_CTRL && w_strb_r[0]
                       && w_data_r[`CTE_CTRL_STOP];
  assign cmd.done    = wr_en && aw_addr_r == `CTE_OFF_CTRL && w_strb_r[0]
                       && w_data_r[`CTE_CTRL_DONE];

  // write channels, either order
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h00000000;
      w_strb_r      <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `CTE_RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_hold_r     <= 1'b1;
        aw_addr_r     <= {S_AXI_AWADDR[7:2], 2'h0};
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_hold_r     <= 1'b1;
        w_data_r     <= S_AXI_WDATA;
        w_strb_r     <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_en)
      begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (aw_addr_r <= `CTE_OFF_RD_ADDR && aw_addr_r != `CTE_OFF_STATUS)
                        ? `CTE_RESP_OKAY : `CTE_RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // software registers
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      cfg_r      <= cte_cfg_t'(`CTE_RST_CONFIG);
      irq_mask_r <= `CTE_RST_MASK;
      rd_addr_r  <= '0;
    end
    else if (wr_en)
    begin
      if (aw_addr_r == `CTE_OFF_CONFIG)
      begin
        cfg_r <= cte_cfg_t'(merge(32'(cfg_r), w_data_r, w_strb_r));
      end
      if (aw_addr_r == `CTE_OFF_IRQ_MASK)
      begin
        irq_mask_r <= 3'(merge({29'h0, irq_mask_r}, w_data_r, w_strb_r));
      end
      if (aw_addr_r == `CTE_OFF_RD_ADDR)
      begin
        rd_addr_r <= w_data_r[AW-1:0];
      end
    end
  end

  // read mux
  always_comb
  begin
    rd_mux  = 32'h00000000;
    rd_resp = `CTE_RESP_OKAY;
    unique case ({S_AXI_ARADDR[7:2], 2'h0})
      `CTE_OFF_CTRL:     rd_mux = 32'h00000000;
      `CTE_OFF_CONFIG:   rd_mux = 32'(cfg_r);
      `CTE_OFF_STATUS:
      begin
        rd_mux[`CTE_ST_STATE_LSB +: 5] = state_r;
        if (cfg_r.adv && state_r == CTE_WAIT)
        begin
          rd_mux[`CTE_ST_TSTATE_LSB +: 4] = TSM_STATE_I;
        end
        if (cfg_r.adv)
        begin
          rd_mux[`CTE_ST_FLAGS_LSB +: 4] = TSM_FLAGS_I;
        end
      end
      `CTE_OFF_WIN:      rd_mux = 32'(win_r);
      `CTE_OFF_SCNT:     rd_mux = 32'(scnt_r);
      `CTE_OFF_TOTAL:    rd_mux = 32'(total_r);
      `CTE_OFF_IRQ_STAT: rd_mux = 32'(irq_stat_r);
      `CTE_OFF_IRQ_MASK: rd_mux = 32'(irq_mask_r);
      `CTE_OFF_RD_ADDR:  rd_mux = 32'(rd_addr_r);
      `CTE_OFF_RD_DATA:  rd_mux = 32'(mem_q);
      `CTE_OFF_KEPT:     rd_mux = 32'(kept_r);
      default:           rd_resp = `CTE_RESP_SLVERR;
    endcase
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `CTE_RESP_OKAY;
    end
    else
    begin
      if (rd_take)
      begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RDATA   <= rd_mux;
        S_AXI_RRESP   <= rd_resp;
      end
      if (S_AXI_RVALID && S_AXI_RREADY)
      begin
        S_AXI_RVALID  <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  // sticky events, set wins over read clear
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      irq_stat_r <= 3'h0;
      IRQ_O      <= 1'b0;
    end
    else
    begin
      if (rd_take && {S_AXI_ARADDR[7:2], 2'h0} == `CTE_OFF_IRQ_STAT)
      begin
        irq_stat_r <= {ev_stop, ev_full, ev_trig};
      end
      else
      begin
        irq_stat_r <= irq_stat_r | {ev_stop, ev_full, ev_trig};
      end
      IRQ_O <= |(irq_stat_r & irq_mask_r);
    end
  end

  // effective window geometry
  always_comb
  begin
    nlog  = (5'(cfg_r.nwin_log2) > 5'(AW)) ? 5'(AW) : 5'(cfg_r.nwin_log2);
    dlog  = (cfg_r.depth_log2 > 5'(AW) - nlog) ? 5'(AW) - nlog : cfg_r.depth_log2;
    dmask = lg_mask(dlog);
    nmask = lg_mask(nlog);
    tpos  = cfg_r.trig_pos[AW-1:0] & dmask;
  end

  assign trig      = imm_r || TRIG_I;
  assign active    = state_r == CTE_PRE || state_r == CTE_WAIT || state_r == CTE_POST;
  assign mem_we    = !cmd.stop && (state_r == CTE_PRE || state_r == CTE_POST
                     || (state_r == CTE_WAIT && trig));
  assign mem_waddr = AW'(win_r << dlog) | scnt_r;
  assign ev_trig   = mem_we && state_r == CTE_WAIT;
  assign ev_full   = (active && !cmd.stop && mem_we && state_r != CTE_PRE
                     && scnt_r == dmask && win_r == nmask);
  assign ev_stop   = active && cmd.stop;

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      state_r <= CTE_IDLE;
      scnt_r  <= '0;
      win_r   <= '0;
      total_r <= '0;
      kept_r  <= '0;
      imm_r   <= 1'b0;
    end
    else
    begin
      if (mem_we)
      begin
        total_r <= total_r + 1'b1;
      end
      unique case (state_r)
        CTE_IDLE:
        begin
          if (cmd.arm || cmd.arm_now)
          begin
            imm_r   <= cmd.arm_now;
            kept_r  <= '0;
            state_r <= (tpos == '0) ? CTE_WAIT : CTE_PRE;
          end
        end
        CTE_PRE, CTE_WAIT, CTE_POST:
        begin
          if (cmd.stop)
          begin
            kept_r  <= (AW+1)'(win_r) + {{AW{1'b0}}, state_r == CTE_POST};
            state_r <= CTE_FULL;
          end
          else if (state_r == CTE_PRE)
          begin
            scnt_r <= scnt_r + 1'b1;
            if (scnt_r == tpos - 1'b1)
            begin
              state_r <= CTE_WAIT;
            end
          end
          else if (mem_we && scnt_r != dmask)
          begin
            scnt_r  <= scnt_r + 1'b1;
            state_r <= CTE_POST;
          end
          else if (mem_we && win_r == nmask)
          begin
            kept_r  <= (AW+1)'(win_r) + 1'b1;
            state_r <= CTE_FULL;
          end
          else if (mem_we)
          begin
            win_r   <= win_r + 1'b1;
            scnt_r  <= '0;
            state_r <= (tpos == '0) ? CTE_WAIT : CTE_PRE;
          end
        end
        CTE_FULL:
        begin
          if (cmd.done)
          begin
            state_r <= CTE_IDLE;
            scnt_r  <= '0;
            win_r   <= '0;
            total_r <= '0;
            imm_r   <= 1'b0;
          end
        end
      endcase
    end
  end

  cte_mem #(
    .W  (PROBE_W + 1),
    .AW (AW)
  ) u_mem (
    .clk_i   (MCLK_I),
    .we_i    (mem_we),
    .waddr_i (mem_waddr),
    .wdata_i ({state_r == CTE_WAIT, PROBE_I}),
    .raddr_i (rd_addr_r),
    .rdata_o (mem_q)
  );

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  chk_arm_to_pre: assert property (state_r == CTE_IDLE && cmd.arm && tpos != '0
    |=> state_r == CTE_PRE) else $error("arm did not enter pre-trigger");
  chk_arm_to_wait: assert property (state_r == CTE_IDLE && cmd.arm && tpos == '0
    |=> state_r == CTE_WAIT) else $error("arm did not enter waiting");
  chk_pre_length: assert property (state_r == CTE_PRE && !cmd.stop && scnt_r == tpos - 1'b1
    |=> state_r == CTE_WAIT && scnt_r == tpos) else $error("pre-trigger length wrong");
  chk_wait_hold: assert property (state_r == CTE_WAIT && !trig && !cmd.stop
    |=> state_r == CTE_WAIT && $stable(total_r)) else $error("left waiting without trigger");
  chk_immediate_trig: assert property (state_r == CTE_WAIT && imm_r && !cmd.stop
    |-> mem_we ##1 state_r != CTE_WAIT || tpos == '0) else $error("immediate arm did not trigger");
  chk_trig_branch: assert property (state_r == CTE_WAIT && trig && !cmd.stop && tpos != dmask
    |=> state_r == CTE_POST) else $error("trigger did not enter post");
  chk_last_full: assert property (state_r != CTE_IDLE && state_r != CTE_FULL && ev_full
    |=> state_r == CTE_FULL && kept_r == (AW+1)'(nmask) + 1'b1) else $error("full missed");
  chk_stop_halt: assert property (ev_stop |=> state_r == CTE_FULL && !mem_we
    && kept_r == (AW+1)'($past(win_r)) + ($past(state_r) == CTE_POST))
    else $error("stop bookkeeping wrong");
  chk_full_frozen: assert property (state_r == CTE_FULL && !cmd.done
    |=> state_r == CTE_FULL && $stable(total_r)) else $error("capture while full");
  chk_idle_zero: assert property (state_r == CTE_IDLE
    |-> scnt_r == '0 && win_r == '0 && total_r == '0) else $error("counters not cleared");
  chk_next_window: assert property (state_r != CTE_PRE && mem_we && tpos == '0
    && scnt_r == dmask && win_r != nmask && !cmd.stop
    |=> state_r == CTE_WAIT && scnt_r == '0) else $error("not ready after window");
  chk_irq_level: assert property (irq_stat_r[`CTE_IRQ_FULL] && irq_mask_r[`CTE_IRQ_FULL]
    |=> IRQ_O) else $error("interrupt not raised");

  cov_full: cover property (state_r == CTE_POST ##1 state_r == CTE_FULL);
  cov_stop_post: cover property (state_r == CTE_POST && cmd.stop);
  cov_multi_win: cover property (state_r == CTE_WAIT && win_r != '0 && trig);
  cov_rearm: cover property (state_r == CTE_FULL ##1 state_r == CTE_IDLE ##[1:50] active);
endmodule : cte_engine
`default_nettype wire

// ### test/cte_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cte_host_model (
  input  wire logic        clk_i,
  output logic [7:0]       awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic [7:0]       araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  initial
  begin
    awaddr_o  = 8'h00;
    awvalid_o = 1'b0;
    wdata_o   = 32'h00000000;
    wvalid_o  = 1'b0;
    bready_o  = 1'b0;
    araddr_o  = 8'h00;
    arvalid_o = 1'b0;
    rready_o  = 1'b0;
  end

  // released payload shows the inverse, never the stale value
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge clk_i);
    awaddr_o  <= a;
    wdata_o   <= d;
    awvalid_o <= 1'b1;
    wvalid_o  <= 1'b1;
    bready_o  <= 1'b1;
    while (!done)
    begin
      @(posedge clk_i);
      if (awvalid_o && awready_i)
      begin
        awvalid_o <= 1'b0;
        awaddr_o  <= ~a;
      end
      if (wvalid_o && wready_i)
      begin
        wvalid_o <= 1'b0;
        wdata_o  <= ~d;
      end
      if (bvalid_i && bready_o)
      begin
        resp = bresp_i;
        bready_o <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge clk_i);
    araddr_o  <= a;
    arvalid_o <= 1'b1;
    rready_o  <= 1'b1;
    while (!done)
    begin
      @(posedge clk_i);
      if (arvalid_o && arready_i)
      begin
        arvalid_o <= 1'b0;
        araddr_o  <= ~a;
      end
      if (rvalid_i && rready_o)
      begin
        d = rdata_i;
        resp = rresp_i;
        rready_o <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rd

  // upload finished, then arm again
  task automatic rearm;
    logic [1:0] r;
    wr(8'h00, 32'h00000008, r);
    wr(8'h00, 32'h00000001, r);
  endtask : rearm
endmodule : cte_host_model
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cte_consts.svh"
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  probe = 8'h00;
  logic        trig = 1'b0;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        irq;
  int          num_errors = 0;
  int          comparisons = 0;
  logic [31:0] cfg_q [2] = '{32'h00020003, 32'h00000000};
  logic [31:0] tot_q [2] = '{32'h4, 32'h1};

  always #2.5 clk = ~clk;
  always @(posedge clk) probe <= probe + 8'h01;

  cte_engine #(.PROBE_W(8), .AW(4)) dut_u (
    .MCLK_I(clk), .RST_I(rst), .PROBE_I(probe), .TRIG_I(trig),
    .TSM_STATE_I(4'hA), .TSM_FLAGS_I(4'h5),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .IRQ_O(irq));

  cte_host_model host_u (
    .clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
    .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
    .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid),
    .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid),
    .rready_o(rready));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: resp %h expected %h", $time, got, exp);
    end
  endtask : chk_resp

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    host_u.wr(a, d, r);
    chk_resp(r, `CTE_RESP_OKAY);
  endtask : wr

  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    host_u.rd(a, d, r);
    chk_resp(r, `CTE_RESP_OKAY);
    chk(d & m, exp);
  endtask : rdm

  // repeated reads until the field matches, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    n = 0;
    do
    begin
      host_u.rd(a, d, r);
      n++;
    end
    while ((d & m) !== exp && n < 40);
    chk(d & m, exp);
  endtask : poll

  task automatic pulse_trig;
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
  endtask : pulse_trig

  task automatic end_of_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test();
  end

  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdm(`CTE_OFF_CONFIG, 32'hFFFFFFFF, 32'h001F0000);
    rdm(`CTE_OFF_STATUS, 32'h1F, 32'h01);
    host_u.rd(8'h30, d, r);
    chk_resp(r, `CTE_RESP_SLVERR);
    host_u.wr(`CTE_OFF_STATUS, 32'hFF, r);
    chk_resp(r, `CTE_RESP_SLVERR);
    // normal arm, depth 16, trigger at 12
    wr(`CTE_OFF_IRQ_MASK, 32'h3);
    wr(`CTE_OFF_CONFIG, 32'h0004000C);
    wr(`CTE_OFF_CTRL, 32'h1);
    rdm(`CTE_OFF_STATUS, 32'h1F, 32'h02);
    poll(`CTE_OFF_STATUS, 32'h1F, 32'h04);
    rdm(`CTE_OFF_TOTAL, 32'hFFFFFFFF, 32'hC);
    pulse_trig();
    poll(`CTE_OFF_STATUS, 32'h1F, 32'h10);
    rdm(`CTE_OFF_TOTAL, 32'hFFFFFFFF, 32'h10);
    rdm(`CTE_OFF_KEPT, 32'hFFFFFFFF, 32'h1);
    wr(`CTE_OFF_RD_ADDR, 32'hC);
    rdm(`CTE_OFF_RD_DATA, 32'h100, 32'h100);
    wr(`CTE_OFF_RD_ADDR, 32'hB);
    rdm(`CTE_OFF_RD_DATA, 32'h100, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rdm(`CTE_OFF_IRQ_STAT, 32'hFFFFFFFF, 32'h3);
    rdm(`CTE_OFF_IRQ_STAT, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(`CTE_OFF_CTRL, 32'h8);
    rdm(`CTE_OFF_STATUS, 32'h1F, 32'h01);
    rdm(`CTE_OFF_WIN, 32'hFFFFFFFF, 32'h0);
    rdm(`CTE_OFF_SCNT, 32'hFFFFFFFF, 32'h0);
    rdm(`CTE_OFF_TOTAL, 32'hFFFFFFFF, 32'h0);
    // immediate arm, last position and one-sample depth, irq masked
    wr(`CTE_OFF_IRQ_MASK, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      wr(`CTE_OFF_CONFIG, cfg_q[i]);
      wr(`CTE_OFF_CTRL, 32'h2);
      poll(`CTE_OFF_STATUS, 32'h1F, 32'h10);
      rdm(`CTE_OFF_TOTAL, 32'hFFFFFFFF, tot_q[i]);
      chk({31'h0, irq}, 32'h0);
      rdm(`CTE_OFF_IRQ_STAT, 32'hFFFFFFFF, 32'h3);
      wr(`CTE_OFF_CTRL, 32'h8);
    end
    // two windows of 4, position 0, stop in second window
    wr(`CTE_OFF_IRQ_MASK, 32'h7);
    wr(`CTE_OFF_CONFIG, 32'h01020000);
    wr(`CTE_OFF_CTRL, 32'h1);
    rdm(`CTE_OFF_STATUS, 32'h1F, 32'h04);
    pulse_trig();
    poll(`CTE_OFF_WIN, 32'hFFFFFFFF, 32'h1);
    rdm(`CTE_OFF_STATUS, 32'h1F, 32'h04);
    wr(`CTE_OFF_CTRL, 32'h4);
    rdm(`CTE_OFF_STATUS, 32'h1F, 32'h10);
    rdm(`CTE_OFF_KEPT, 32'hFFFFFFFF, 32'h1);
    pulse_trig();
    wr(`CTE_OFF_CTRL, 32'h1);
    rdm(`CTE_OFF_TOTAL, 32'hFFFFFFFF, 32'h4);
    rdm(`CTE_OFF_STATUS, 32'h1F, 32'h10);
    wr(`CTE_OFF_RD_ADDR, 32'h0);
    rdm(`CTE_OFF_RD_DATA, 32'h100, 32'h100);
    wr(`CTE_OFF_RD_ADDR, 32'h4);
    rdm(`CTE_OFF_RD_DATA, 32'h100, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rdm(`CTE_OFF_IRQ_STAT, 32'hFFFFFFFF, 32'h5);
    // advanced mode readback, re-armed by the host
    wr(`CTE_OFF_CONFIG, 32'h80020000);
    host_u.rearm();
    rdm(`CTE_OFF_STATUS, 32'hFFFF, 32'h5A04);
    wr(`CTE_OFF_CTRL, 32'h4);
    rdm(`CTE_OFF_STATUS, 32'hFFFF, 32'h5010);
    rdm(`CTE_OFF_KEPT, 32'hFFFFFFFF, 32'h0);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
